//--- hw/swa_top.sv
// SYSREF window detector and automatic alignment, with its register port.
// Assumes the delayed SYSREF taps and the alignment comparator are
// synchronous to clk_sys and that SYSREF keeps running during a search.
//
// How it works
// - Step option bit 0 selects coarse window spacing, 1 selects fine.
// - Window status positions 0 and 23 always read as one.
// - Capture phase select is the binary index of a window position.
// - Window is 24 positions; select reaches only positions 0 to 15.
// - A status bit is one when its position risks setup or hold.
// - Window status is valid only after three SYSREF rising edges.
// - Invert bit adds half a clock period to coarse and fine delay.
// - Enable starts stepping delay until falling clock meets SYSREF.
// - Done flag rises when the search has finished.
// - The found delay setting is readable after the search.
// - After a hit the found delay stays applied while enable stays set; after a miss the last trial stays applied.
// - With alignment disabled, manual delay writes are accepted.
// - Search tries both polarities and takes the smallest coarse code.
// - Window bits sit in three byte registers, low delay lowest.
//
// The implementer's own choice: strobed register access.
module swa_top (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // Register port.
  input  wire swa_pkg::swa_bus_type   bus,
  output logic [31:0]                 rdata_q,
  // Analog observations.
  input  wire logic [23:0]            sref_taps,
  input  wire logic                   align_hit,
  // Analog controls.
  output swa_pkg::swa_delay_type      apt_delay_q,
  output logic                        step_fine_q,
  output logic [3:0]                  capture_sel_q,
  output logic                        sysref_cap_q
);
  `include "swa_cfg.svh"

  //--------------------------------------------------------------------
  // Submodules
  //--------------------------------------------------------------------

  swa_pkg::swa_top_type   q, d;
  swa_pkg::swa_delay_type trial;
  logic [23:0]            win;
  logic                   win_valid;
  logic                   sref_edge;
  logic                   busy;
  logic                   finish;
  logic                   miss;
  logic                   start;

  // Window detector and phase capture.
  swa_detector u_det (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .sref_taps (sref_taps),
    .sel       (q.sel),
    .restart   (q.restart),
    .win_q     (win),
    .valid_q   (win_valid),
    .edge_q    (sref_edge),
    .cap_q     (sysref_cap_q)
  );

  // Aperture delay search.
  swa_search u_srch (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .start       (start),
    .abort       (!q.en),
    .fine_code   (q.cfg[7:0]),
    .trial_edges (q.cfg[`SWA_F_EDGES +: 4]),
    .sref_edge   (sref_edge),
    .align_hit   (align_hit),
    .busy_q      (busy),
    .finish_q    (finish),
    .miss_q      (miss),
    .trial_q     (trial)
  );

  //--------------------------------------------------------------------
  // Register port
  //--------------------------------------------------------------------

  // True when the access targets the given register index.
  function automatic logic at(input logic [11:0] a, input logic [9:0] ix);
    return (a[1:0] == 2'h0) && (a[11:2] == ix);
  endfunction

  // A write of one to the enable bit while it is clear starts a search.
  assign start = bus.we && at(bus.addr, `SWA_IX_EN) && bus.wdata[0] && !q.en;

  // Next state of the control registers and the read answer.
  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;
    d.restart = 1'b0;
    if (bus.we && at(bus.addr, `SWA_IX_CLKCTL)) begin
      d.sel = bus.wdata[3:0];
      d.step = bus.wdata[`SWA_F_STEP];
      d.restart = (bus.wdata[`SWA_F_STEP] != q.step);
    end
    if (bus.we && at(bus.addr, `SWA_IX_CFG)) begin
      d.cfg = bus.wdata[11:0];
    end
    if (bus.we && at(bus.addr, `SWA_IX_EN)) begin
      d.en = bus.wdata[0];
    end
    if (start) begin
      d.done = 1'b0;
      d.miss = 1'b0;
    end
    if (busy) begin
      d.delay = trial;
    end
    if (finish) begin
      d.done = 1'b1;
      d.miss = miss;
      if (!miss) begin
        d.found = trial;
        d.delay = trial;
      end
    end
    if (bus.we && at(bus.addr, `SWA_IX_DELAY) && !q.en) begin
      d.delay.fine = bus.wdata[7:0];
      d.delay.coarse = bus.wdata[`SWA_F_COARSE +: 8];
      d.delay.inv = bus.wdata[`SWA_F_INV];
    end
    if (bus.re && bus.addr[1:0] == 2'h0) begin
      unique case (bus.addr[11:2])
        `SWA_IX_CLKCTL:  d.rdata = {27'h0, q.step, q.sel};
        `SWA_IX_WIN_LO:  d.rdata = {24'h0, win[7:0]};
        `SWA_IX_WIN_MID: d.rdata = {24'h0, win[15:8]};
        `SWA_IX_WIN_HI:  d.rdata = {24'h0, win[23:16]};
        `SWA_IX_CFG:     d.rdata = {20'h0, q.cfg};
        `SWA_IX_EN:      d.rdata = {31'h0, q.en};
        `SWA_IX_STAT:    d.rdata = {28'h0, busy, win_valid, q.miss, q.done};
        `SWA_IX_FOUND:   d.rdata = {15'h0, q.found};
        `SWA_IX_DELAY:   d.rdata = {15'h0, q.delay};
        default:         d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; every output except sysref_cap_q is taken from here.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '{sel: 4'h0, step: 1'b0, cfg: `SWA_CFG_RST, en: 1'b0, done: 1'b0,
             miss: 1'b0, restart: 1'b0, delay: '0, found: '0,
             rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------

  // The delay lines follow the register; invert adds half a period.
  assign apt_delay_q   = q.delay;
  assign step_fine_q   = q.step;
  assign capture_sel_q = q.sel;
  assign rdata_q       = q.rdata;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_ends_set;
    win[0] && win[23];
  endproperty
  a_ends_set: assert property (p_ends_set)
    else $error("Window end positions are not set.");

  property p_step_write;
    (bus.we && at(bus.addr, `SWA_IX_CLKCTL)) |=> step_fine_q == $past(bus.wdata[4]);
  endproperty
  a_step_write: assert property (p_step_write)
    else $error("Step option did not follow its write.");

  property p_done_clear;
    start |=> !q.done throughout busy [*2];
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("Done flag not cleared by a new search.");

  property p_done_set;
    finish |=> q.done;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("Done flag missing after search end.");

  property p_found_applied;
    (finish && !miss) |=> (q.found == $past(trial)) && (apt_delay_q == q.found);
  endproperty
  a_found_applied: assert property (p_found_applied)
    else $error("Found delay not recorded or applied.");

  property p_delay_kept;
    (q.en && !busy && !finish) |=> $stable(apt_delay_q);
  endproperty
  a_delay_kept: assert property (p_delay_kept)
    else $error("Applied delay changed without a search or write.");

  property p_manual_write;
    (bus.we && at(bus.addr, `SWA_IX_DELAY) && !q.en && !busy)
      |=> apt_delay_q == $past(bus.wdata[16:0]);
  endproperty
  a_manual_write: assert property (p_manual_write)
    else $error("Manual delay write was not accepted.");

  property p_valid_after_edges;
    $rose(win_valid) |-> sref_edge;
  endproperty
  a_valid_after_edges: assert property (p_valid_after_edges)
    else $error("Window became valid without a SYSREF edge.");

  property p_window_update;
    !sref_edge |-> $stable(win);
  endproperty
  a_window_update: assert property (p_window_update)
    else $error("Window status changed without a SYSREF edge.");

  property p_read_once;
    !bus.re |=> rdata_q == 32'h0000_0000;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("Read data held outside its answer cycle.");

  // Capture select follows its register write.
  property p_sel_write;
    (bus.we && at(bus.addr, `SWA_IX_CLKCTL)) |=> capture_sel_q == $past(bus.wdata[3:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("Capture select did not follow its write.");

  // A new search leaves idle at once.
  property p_start_busy;
    (start && !busy) |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("Search did not start on the enable write.");

  // The first trial is the smallest coarse code without inversion.
  property p_first_trial;
    (start && !busy) |=> ##1 (!apt_delay_q.inv && apt_delay_q.coarse == 8'h00);
  endproperty
  a_first_trial: assert property (p_first_trial)
    else $error("Search did not begin at the smallest delay.");

  // A failed search leaves the found setting untouched.
  property p_miss_keeps_found;
    (finish && miss) |=> $stable(q.found);
  endproperty
  a_miss_keeps_found: assert property (p_miss_keeps_found)
    else $error("Found setting changed by a failed search.");

  // Reading the found register returns the stored setting.
  property p_found_read;
    (bus.re && at(bus.addr, `SWA_IX_FOUND)) |=> rdata_q == {15'h0, $past(q.found)};
  endproperty
  a_found_read: assert property (p_found_read)
    else $error("Found setting read back wrongly.");

  // A change of step option restarts the edge count.
  property p_step_restart;
    (bus.we && at(bus.addr, `SWA_IX_CLKCTL) && bus.wdata[4] != step_fine_q)
      |=> ##1 !win_valid;
  endproperty
  a_step_restart: assert property (p_step_restart)
    else $error("Window stayed valid after a step option change.");

  // The lowest window byte reads the smallest-delay positions.
  property p_win_lo_read;
    (bus.re && at(bus.addr, `SWA_IX_WIN_LO)) |=> rdata_q == {24'h0, $past(win[7:0])};
  endproperty
  a_win_lo_read: assert property (p_win_lo_read)
    else $error("Low window byte read back wrongly.");

  // The highest window byte reads the largest-delay positions.
  property p_win_hi_read;
    (bus.re && at(bus.addr, `SWA_IX_WIN_HI)) |=> rdata_q == {24'h0, $past(win[23:16])};
  endproperty
  a_win_hi_read: assert property (p_win_hi_read)
    else $error("High window byte read back wrongly.");

  // The enable bit follows its register write.
  property p_en_write;
    (bus.we && at(bus.addr, `SWA_IX_EN)) |=> q.en == $past(bus.wdata[0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("Enable bit did not follow its write.");

  c_found: cover property (finish && !miss);
  c_miss: cover property (finish && miss);
  c_valid: cover property ($rose(win_valid));
  c_manual: cover property (bus.we && at(bus.addr, `SWA_IX_DELAY) && !q.en);
  c_restart: cover property (q.restart);
endmodule

//--- hw/swa_cfg.svh
// Constants of the SYSREF window and alignment block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SWA_CFG_SVH
`define SWA_CFG_SVH

// Register indices; the byte address is four times the index.
`define SWA_IX_CLKCTL  10'h029
`define SWA_IX_WIN_LO  10'h02C
`define SWA_IX_WIN_MID 10'h02D
`define SWA_IX_WIN_HI  10'h02E
`define SWA_IX_CFG     10'h030
`define SWA_IX_EN      10'h031
`define SWA_IX_STAT    10'h032
`define SWA_IX_FOUND   10'h033
`define SWA_IX_DELAY   10'h034

// Field positions.
`define SWA_F_STEP     4
`define SWA_F_EDGES    8
`define SWA_F_COARSE   8
`define SWA_F_INV      16

// Reset values.
`define SWA_WIN_RST    24'h800001
`define SWA_CFG_RST    12'h100

// Counts and timing.
`define SWA_EDGES_VALID 2'h3
`define SWA_COARSE_MAX  8'hFF
`define SWA_CLK_MHZ     50
`define SWA_SETTLE_NS   100
`define SWA_SETTLE_CYC  ((`SWA_SETTLE_NS * `SWA_CLK_MHZ + 999) / 1000)

`endif

//--- hw/swa_pkg.sv
// Types shared by the SYSREF window and alignment modules.
// Assumes nothing beyond a SystemVerilog compiler.
package swa_pkg;

  // One aperture delay setting.
  typedef struct packed {
    logic       inv;
    logic [7:0] coarse;
    logic [7:0] fine;
  } swa_delay_type;

  // Register port of the block.
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } swa_bus_type;

  // Search controller states.
  typedef enum logic [3:0] {
    SWA_IDLE   = 4'h1,
    SWA_SETTLE = 4'h2,
    SWA_WAIT   = 4'h4,
    SWA_DONE   = 4'h8
  } swa_state_type;

  typedef struct packed {
    swa_state_type st;
    swa_delay_type trial;
    logic [7:0]    cnt;
    logic [3:0]    edges;
    logic          finish;
    logic          miss;
  } swa_search_type;

  typedef struct packed {
    logic        ref_prev;
    logic [1:0]  seen;
    logic [23:0] win;
    logic        edge_p;
    logic        cap;
  } swa_det_type;

  typedef struct packed {
    logic [3:0]    sel;
    logic          step;
    logic [11:0]   cfg;
    logic          en;
    logic          done;
    logic          miss;
    logic          restart;
    swa_delay_type delay;
    swa_delay_type found;
    logic [31:0]   rdata;
  } swa_top_type;

endpackage

//--- hw/swa_detector.sv
// SYSREF position detector: window status, edge count and phase capture.
// Assumes the 24 delayed SYSREF samples arrive synchronous to clk_sys.
module swa_detector (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Delayed samples and selection.
  input  wire logic [23:0] sref_taps,
  input  wire logic [3:0]  sel,
  input  wire logic        restart,
  // Results.
  output logic      [23:0] win_q,
  output logic             valid_q,
  output logic             edge_q,
  output logic             cap_q
);
  `include "swa_cfg.svh"

  swa_pkg::swa_det_type q, d;

  // Marks a position that differs from either neighbour; both end positions are forced to one.
  function automatic logic [23:0] risk(input logic [23:0] t);
    logic [23:0] r;
    r = '1;
    for (int i = 1; i < 23; i++) begin
      r[i] = (t[i-1] ^ t[i]) | (t[i] ^ t[i+1]);
    end
    return r;
  endfunction

  // Next state: new window on every rising edge, capture every cycle.
  always_comb begin
    d = q;
    d.ref_prev = sref_taps[0];
    d.edge_p = sref_taps[0] & ~q.ref_prev;
    d.cap = sref_taps[sel];
    if (d.edge_p) begin
      d.win = risk(sref_taps);
    end
    if (restart) begin
      d.seen = 2'h0;
    end else if (d.edge_p && q.seen != `SWA_EDGES_VALID) begin
      d.seen = q.seen + 2'h1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '{ref_prev: 1'b0, seen: 2'h0, win: `SWA_WIN_RST, edge_p: 1'b0, cap: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign win_q   = q.win;
  assign valid_q = (q.seen == `SWA_EDGES_VALID);
  assign edge_q  = q.edge_p;
  assign cap_q   = q.cap;

  property p_cap_follows_sel;
    @(posedge clk_sys) disable iff (srst)
    ##1 cap_q == $past(sref_taps[sel]);
  endproperty
  a_cap_follows_sel: assert property (p_cap_follows_sel)
    else $error("Captured level is not the selected tap.");
endmodule

//--- hw/swa_search.sv
// Alignment search: steps coarse codes, both clock polarities, until a hit.
// Assumes align_hit is valid in each cycle in which sref_edge pulses.
`include "swa_cfg.svh"
module swa_search #(
  parameter int unsigned SETTLE = `SWA_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // Control.
  input  wire logic                   start,
  input  wire logic                   abort,
  input  wire logic [7:0]             fine_code,
  input  wire logic [3:0]             trial_edges,
  // Observations.
  input  wire logic                   sref_edge,
  input  wire logic                   align_hit,
  // Results.
  output logic                        busy_q,
  output logic                        finish_q,
  output logic                        miss_q,
  output swa_pkg::swa_delay_type      trial_q
);
  `include "swa_cfg.svh"

  if (SETTLE < 1 || SETTLE > 255) begin : g_chk
    $error("SETTLE must lie in 1..255.");
  end

  swa_pkg::swa_search_type q, d;
  logic [3:0] need;

  // Walk: inv 0 then inv 1 at each coarse code, so the first hit is the smallest.
  always_comb begin
    d = q;
    d.finish = 1'b0;
    need = (trial_edges == 4'h0) ? 4'h1 : trial_edges;
    unique case (q.st)
      swa_pkg::SWA_IDLE: begin
        if (start) begin
          d.trial = '{inv: 1'b0, coarse: 8'h00, fine: fine_code};
          d.cnt = 8'(SETTLE);
          d.miss = 1'b0;
          d.st = swa_pkg::SWA_SETTLE;
        end
      end
      swa_pkg::SWA_SETTLE: begin
        d.edges = 4'h0;
        d.cnt = q.cnt - 8'h01;
        if (q.cnt == 8'h01) begin
          d.st = swa_pkg::SWA_WAIT;
        end
      end
      swa_pkg::SWA_WAIT: begin
        if (sref_edge) begin
          d.edges = q.edges + 4'h1;
          if (d.edges >= need) begin
            d.cnt = 8'(SETTLE);
            d.st = swa_pkg::SWA_SETTLE;
            if (align_hit) begin
              d.st = swa_pkg::SWA_DONE;
            end else if (q.trial.inv && q.trial.coarse == `SWA_COARSE_MAX) begin
              d.miss = 1'b1;
              d.st = swa_pkg::SWA_DONE;
            end else if (!q.trial.inv) begin
              d.trial.inv = 1'b1;
            end else begin
              d.trial.inv = 1'b0;
              d.trial.coarse = q.trial.coarse + 8'h01;
            end
          end
        end
      end
      swa_pkg::SWA_DONE: begin
        d.finish = 1'b1;
        d.st = swa_pkg::SWA_IDLE;
      end
    endcase
    if (abort && q.st != swa_pkg::SWA_IDLE && q.st != swa_pkg::SWA_DONE) begin
      d.st = swa_pkg::SWA_IDLE;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '{st: swa_pkg::SWA_IDLE, trial: '0, cnt: 8'h00, edges: 4'h0,
             finish: 1'b0, miss: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign busy_q   = (q.st != swa_pkg::SWA_IDLE);
  assign finish_q = q.finish;
  assign miss_q   = q.miss;
  assign trial_q  = q.trial;

  property p_walk_order;
    @(posedge clk_sys) disable iff (srst)
    (busy_q && $past(busy_q) && trial_q != $past(trial_q)) |->
      (trial_q.inv ? trial_q.coarse == $past(trial_q.coarse)
                   : trial_q.coarse == $past(trial_q.coarse) + 8'h01);
  endproperty
  a_walk_order: assert property (p_walk_order)
    else $error("Search did not step polarity before coarse code.");
endmodule

//--- dv/swa_sref_source.sv
// Clock source model: a periodic SYSREF seen through the 24 delay taps.
// Assumes the bench holds pattern at zero until SYSREF is to run.
module swa_sref_source #(
  parameter int unsigned PERIOD = 16
) (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // Stimulus from the bench.
  input  wire logic [23:0]            pattern,
  input  wire logic [8:0]             tgt0,
  input  wire logic [8:0]             tgt1,
  // Delay applied by the block.
  input  wire swa_pkg::swa_delay_type apt_delay_q,
  // Far side outputs.
  output logic      [23:0]            sref_taps,
  output logic                        align_hit
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned ph;
  logic [23:0] pat_q;
  logic        hit;

  // The phase runs without gaps, so each trial is sure to see edges.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ph    <= 0;
      pat_q <= 24'h000000;
    end else begin
      ph <= (ph == PERIOD - 1) ? 0 : ph + 1;
      if (ph == 0) pat_q <= pattern;
    end
  end

  // Taps show the pulse for three cycles; the comparator toggles when unsampled.
  assign sref_taps = (ph >= 1 && ph <= 3) ? pat_q : 24'h000000;
  assign hit       = {1'b0, apt_delay_q.coarse} == (apt_delay_q.inv ? tgt1 : tgt0);
  assign align_hit = (ph == 2) ? hit : ph[0];
endmodule

//--- dv/sysref_window_auto_align_test.sv
// Self-checking bench of swa_top against a behavioural model.
// Assumes swa_cfg.svh on the include path and the clock source model.
`include "swa_cfg.svh"
module sysref_window_auto_align_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   clk_sys;
  logic                   srst;
  swa_pkg::swa_bus_type   bus;
  logic [31:0]            rdata_q;
  logic [23:0]            sref_taps;
  logic                   align_hit;
  swa_pkg::swa_delay_type apt_delay_q;
  logic                   step_fine_q;
  logic [3:0]             capture_sel_q;
  logic                   sysref_cap_q;
  logic [23:0]            pattern;
  logic [8:0]             tgt0;
  logic [8:0]             tgt1;
  logic [31:0]            rd;
  logic                   step_m;
  logic                   prev;
  logic [16:0]            found_m = 17'h00000;
  int                     error_cnt = 0;
  int                     n_tests = 0;
  int                     seed = 40;
  int                     cyc = 0;
  int                     n_rise = 0;
  logic                   tap_prev = 1'b0;
  logic [9:0]  rst_ix [9] = '{`SWA_IX_CLKCTL, `SWA_IX_WIN_LO, `SWA_IX_WIN_MID, `SWA_IX_WIN_HI,
                              `SWA_IX_CFG, `SWA_IX_EN, `SWA_IX_STAT, `SWA_IX_FOUND, 10'h03F};
  logic [31:0] rst_v  [9] = '{32'h0, 32'h1, 32'h0, 32'h80, 32'h100, 32'h0, 32'h0, 32'h0, 32'h0};

  swa_top i_dut (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .bus           (bus),
    .rdata_q       (rdata_q),
    .sref_taps     (sref_taps),
    .align_hit     (align_hit),
    .apt_delay_q   (apt_delay_q),
    .step_fine_q   (step_fine_q),
    .capture_sel_q (capture_sel_q),
    .sysref_cap_q  (sysref_cap_q)
  );

  swa_sref_source #(.PERIOD(16)) i_src (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .pattern     (pattern),
    .tgt0        (tgt0),
    .tgt1        (tgt1),
    .apt_delay_q (apt_delay_q),
    .sref_taps   (sref_taps),
    .align_hit   (align_hit)
  );

  // Free running clock of 20 ns.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // A hang past the cycle ceiling counts as a mismatch.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("unexpected run length expected below 40000 seen %0d", cyc);
      tally_and_finish();
    end
  end

  // Counts rising samples of the earliest tap, as the detector takes them.
  always @(posedge clk_sys) begin
    tap_prev <= sref_taps[0];
    if (sref_taps[0] === 1'b1 && tap_prev === 1'b0) n_rise <= n_rise + 1;
  end

  // Compares one value and counts it.
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write cycle on the register port.
  task automatic wr(logic [9:0] ix, logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: {ix, 2'h0}, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_sys);
    bus.we <= 1'b0;
  endtask

  // One read cycle; the answer stands for one cycle only.
  task automatic rd_at(logic [9:0] ix, logic [1:0] lo = 2'h0);
    @(posedge clk_sys);
    bus.addr <= {ix, lo};
    bus.re   <= 1'b1;
    @(posedge clk_sys);
    bus.re <= 1'b0;
    #1 rd = rdata_q;
    @(posedge clk_sys);
    #1 chk("idle rdata", 32'h0, rdata_q);
  endtask

  // Waits for n more rising samples of the earliest tap, then lets the window settle.
  task automatic rises(int n);
    int base;
    base = n_rise;
    while (n_rise < base + n) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
  endtask

  // Expected window: a position is at risk where its tap differs from a neighbour.
  function automatic logic [23:0] exp_win(logic [23:0] p);
    logic [23:0] w;
    w = 24'h800001;
    for (int i = 1; i < 23; i++) w[i] = (p[i] != p[i-1]) || (p[i] != p[i+1]);
    return w;
  endfunction

  // Search order inv0 c0, inv1 c0, inv0 c1 ...; result 2*coarse+inv, 512 if none.
  function automatic int first_hit(logic [8:0] t0, logic [8:0] t1);
    for (int c = 0; c < 256; c++) begin
      if (c == t0) return 2 * c;
      if (c == t1) return 2 * c + 1;
    end
    return 512;
  endfunction

  // Manual delay write with alignment disabled.
  task automatic manual();
    logic [16:0] d;
    d = 17'($random(seed));
    wr(`SWA_IX_DELAY, {15'h0, d});
    @(posedge clk_sys) #1 chk("manual delay", {15'h0, d}, apt_delay_q);
    rd_at(`SWA_IX_DELAY);
    chk("delay readback", {15'h0, d}, rd);
  endtask

  // One alignment search against the model's targets.
  task automatic search(logic [8:0] t0, logic [8:0] t1, logic [3:0] n);
    int          k;
    logic [7:0]  fine;
    logic [16:0] exp_d;
    fine  = 8'($random(seed));
    k     = first_hit(t0, t1);
    exp_d = {k[0] | (k == 512), (k == 512) ? 8'hFF : k[8:1], fine};
    tgt0 <= t0;
    tgt1 <= t1;
    wr(`SWA_IX_CFG, {20'h0, n, fine});
    wr(`SWA_IX_EN, 32'h1);
    rd_at(`SWA_IX_STAT);
    chk("stat running", 32'hC, rd);
    for (int i = 0; i < 5000 && rd[0] !== 1'b1; i++) rd_at(`SWA_IX_STAT);
    chk("stat finished", (k == 512) ? 32'h7 : 32'h5, rd);
    if (k != 512) found_m = exp_d;
    rd_at(`SWA_IX_FOUND);
    chk("found", {15'h0, found_m}, rd);
    chk("applied delay", {15'h0, exp_d}, apt_delay_q);
    rd_at(`SWA_IX_CFG);
    chk("cfg", {20'h0, n, fine}, rd);
    wr(`SWA_IX_DELAY, 32'($random(seed)) & 32'h1FFFF);
    @(posedge clk_sys) #1 chk("kept delay", {15'h0, exp_d}, apt_delay_q);
    wr(`SWA_IX_EN, 32'h0);
    manual();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    bus     = '0;
    pattern = 24'h000000;
    tgt0    = 9'h100;
    tgt1    = 9'h100;
    srst    = 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    chk("reset delay", 32'h0, apt_delay_q);
    wr(`SWA_IX_WIN_LO, 32'hFF);
    for (int j = 0; j < 9; j++) begin
      rd_at(rst_ix[j]);
      chk("reset value", rst_v[j], rd);
    end
    rd_at(`SWA_IX_CFG, 2'h1);
    chk("misaligned read", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      step_m = i[0];
      wr(`SWA_IX_CLKCTL, {27'h0, step_m, 4'h0});
      pattern <= 24'($random(seed)) | 24'h000001;
      @(posedge clk_sys) #1 chk("step option", {31'h0, step_m}, step_fine_q);
      rises(2);
      rd_at(`SWA_IX_STAT);
      chk("valid after two", 32'h0, rd & 32'h4);
      for (int j = 0; j < 3; j++) begin
        rd_at(10'(`SWA_IX_WIN_LO + j));
        chk("window byte", (exp_win(pattern) >> (8 * j)) & 24'hFF, rd);
      end
      rises(1);
      rd_at(`SWA_IX_STAT);
      chk("valid after three", 32'h4, rd & 32'h4);
    end
    for (int s = 0; s < 16; s++) begin
      wr(`SWA_IX_CLKCTL, {27'h0, step_m, 4'(s)});
      repeat (2) @(posedge clk_sys);
      #1 chk("capture select", 32'(s), capture_sel_q);
      prev = sref_taps[s];
      repeat (20) begin
        @(posedge clk_sys) #1 chk("captured sysref", {31'h0, prev}, sysref_cap_q);
        prev = sref_taps[s];
      end
    end
    wr(`SWA_IX_CLKCTL, {27'h0, step_m, 4'h0});
    for (int i = 0; i < 3; i++) search(9'($random(seed)) & 9'h7, 9'($random(seed)) & 9'h7, 4'(i));
    search(9'h100, 9'h100, 4'h1);
    wr(`SWA_IX_EN, 32'h1);
    repeat (40) @(posedge clk_sys);
    wr(`SWA_IX_EN, 32'h0);
    rd_at(`SWA_IX_STAT);
    chk("stat aborted", 32'h4, rd);
    manual();
    tally_and_finish();
  end
endmodule
